// [core/sar_seq_regs.vh]
// Register offsets, field positions and timing counts for the converter sequencer
`ifndef SAR_SEQ_REGS_VH
`define SAR_SEQ_REGS_VH
`define OFS_STATUS_CONTROL   4'h0
`define OFS_RESULT_HIGH      4'h4
`define OFS_RESULT_LOW       4'h8
`define OFS_CLOCK_CONFIG     4'hC
`define SC_DONE_BIT          7
`define SC_IRQ_EN_BIT        6
`define SC_CONT_BIT          5
`define CC_PRESCALE_HI       7
`define CC_PRESCALE_LO       5
`define CC_SRC_SEL_BIT       4
`define CC_FMT_HI_BIT        3
`define CC_FMT_LO_BIT        2
`define SC_RESET_VAL         8'h1F
`define CC_RESET_VAL         8'h00
`define CH_UPPER_REF         5'h1D
`define CH_LOWER_REF         5'h1E
`define CH_POWER_OFF         5'h1F
`define CH_LAST_PIN          5'h09
`define CODE_FULL_SCALE      10'h3FF
`define CODE_ZERO_SCALE      10'h000
`define CONV_ADC_CYCLES      5'h10
`endif

// [core/sar_adc_sequencer.v]
// Control logic of a 10-bit successive-approximation converter with Wishbone registers
//
// Design decisions made here: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "sar_seq_regs.vh"
// Notes on behaviour
// - Selected pin taken from port logic
// - Port writes ignored on selected pin
// - Port read of claimed pin returns 0
// - Reference inputs give 3FF and 000
// - Status/control write starts a conversion unless channel is all ones
// - Conversion lasts 16 to 17 converter clocks
// - Partial first cycle counts as seventeenth
// - Source select picks bus or crystal clock
// - Continuous mode overwrites both result registers, only the low one when truncated
// - Continuous conversions repeat until bit cleared
// - Done flag set by first continuous conversion only
// - Four result formats via two-bit field
// - Left: high eight bits, low two bits
// - High read locks results until low read
// - Right: top two high, eight low
// - Signed left inverts result bit nine
// - Truncated: upper eight in low, no interlock
// - Interrupt enable requests interrupt per conversion
// - With interrupts, done flag reads zero
// - Keeps running in wait; interrupt wakes
// - Ten channels shared with two ports
// - Codes 0-9 pins, 1D/1E references
// - All-ones channel code powers off
// - Prescaler 1,2,4,8, top bit sixteen
// - Status/control write aborts running conversion
module sar_adc_sequencer #(
  parameter [1:0] FMT_LEFT   = 2'h0,
  parameter [1:0] FMT_RIGHT  = 2'h1,
  parameter [1:0] FMT_SIGNED = 2'h2,
  parameter [1:0] FMT_TRUNC  = 2'h3,
  parameter       NCH        = 10
) (
  input  wire            CLK_I,        // Bus clock, 200 MHz
  input  wire            SRST_I,       // Synchronous reset, active high
  input  wire            CYC_I,        // Wishbone cycle
  input  wire            STB_I,        // Wishbone strobe
  input  wire            WE_I,         // Wishbone write enable
  input  wire [3:0]      ADR_I,        // Wishbone byte address
  input  wire [3:0]      SEL_I,        // Wishbone byte selects
  input  wire [31:0]     DAT_I,        // Wishbone write data
  output reg  [31:0]     DAT_O,        // Wishbone read data
  output reg             ACK_O,        // Wishbone acknowledge
  input  wire            XTAL_TICK_I,  // Crystal reference clock, sampled
  input  wire            CMP_HIGH_I,   // Analog comparator: input at or above trial
  output wire [9:0]      TRIAL_CODE_O, // Trial code to resistor array
  output wire [4:0]      ANALOG_SEL_O, // Analog multiplexer select
  output wire            ANALOG_PWR_O, // Converter analog power enable
  output wire            IRQ_O,        // Conversion interrupt request
  input  wire [NCH-1:0]  PORT_OUT_I,   // Port logic output levels
  input  wire [NCH-1:0]  PORT_DIR_I,   // Port logic directions, 1 = output
  input  wire [NCH-1:0]  PIN_LEVEL_I,  // Pin levels
  output wire [NCH-1:0]  PIN_OUT_O,    // Pin drive levels
  output wire [NCH-1:0]  PIN_OE_O,     // Pin output enables
  output wire [NCH-1:0]  PORT_READ_O   // Pin levels seen by port reads
);
  localparam ST_IDLE = 2'h0;
  localparam ST_SYNC = 2'h1;
  localparam ST_CONV = 2'h2;

  reg  [4:0]  chan_r;
  reg         cont_r;
  reg         irq_en_r;
  reg         done_r;
  reg         irq_r;
  reg  [7:0]  clk_cfg_r;
  reg  [1:0]  state_r;
  reg  [4:0]  step_r;
  reg  [9:0]  sar_r;
  reg  [3:0]  div_cnt_r;
  reg         xtal_d_r;
  reg  [7:0]  res_hi_r;
  reg  [7:0]  res_lo_r;
  reg         lock_r;
  reg         first_done_r;
  reg         ack_nxt;

  wire        req       = CYC_I & STB_I & ~ACK_O;
  wire        wr        = req & WE_I & SEL_I[0];
  wire        rd        = req & ~WE_I;
  wire        wr_sc     = wr & (ADR_I == `OFS_STATUS_CONTROL);
  wire        rd_hi     = rd & (ADR_I == `OFS_RESULT_HIGH);
  wire        rd_lo     = rd & (ADR_I == `OFS_RESULT_LOW);
  wire [1:0]  fmt       = clk_cfg_r[`CC_FMT_HI_BIT:`CC_FMT_LO_BIT];
  wire        pin_sel   = chan_r <= `CH_LAST_PIN;
  wire        powered   = chan_r != `CH_POWER_OFF;

  // Selected-pin one-hot, shared by the port override paths
  function [NCH-1:0] pin_mask;
    input [4:0] ch;
    integer k;
    begin
      pin_mask = {NCH{1'b0}};
      for (k = 0; k < NCH; k = k + 1) begin
        if (ch == k[4:0])
          pin_mask[k] = 1'b1;
      end
    end
  endfunction

  wire [NCH-1:0] claim = pin_sel ? pin_mask(chan_r) : {NCH{1'b0}};
  assign PIN_OUT_O    = PORT_OUT_I & ~claim;
  assign PIN_OE_O     = PORT_DIR_I & ~claim;
  assign PORT_READ_O  = PIN_LEVEL_I & ~claim;
  assign ANALOG_SEL_O = chan_r;
  assign ANALOG_PWR_O = powered;
  assign IRQ_O        = irq_r;

  // Converter clock: source select then prescaler
  wire xtal_edge = XTAL_TICK_I & ~xtal_d_r;
  wire src_tick  = clk_cfg_r[`CC_SRC_SEL_BIT] ? 1'b1 : xtal_edge;
  reg  [3:0] div_max;
  always @* begin
    case (clk_cfg_r[`CC_PRESCALE_HI:`CC_PRESCALE_LO])
      3'h0:    div_max = 4'h0;
      3'h1:    div_max = 4'h1;
      3'h2:    div_max = 4'h3;
      3'h3:    div_max = 4'h7;
      default: div_max = 4'hF;
    endcase
  end
  wire adc_tick = src_tick & (div_cnt_r >= div_max);

  // Result value: references forced, pins from the successive approximation
  wire [9:0] trial = sar_r | (10'h200 >> step_r[3:0]);
  assign TRIAL_CODE_O = trial;
  wire [9:0] final_code = (chan_r == `CH_UPPER_REF) ? `CODE_FULL_SCALE :
                          (chan_r == `CH_LOWER_REF) ? `CODE_ZERO_SCALE :
                          sar_r;
  wire conv_end = (state_r == ST_CONV) & adc_tick & (step_r == `CONV_ADC_CYCLES - 5'h1);
  wire interlock = (fmt != FMT_TRUNC);
  wire store = conv_end & ~(interlock & lock_r);

  always @(posedge CLK_I) begin
    if (SRST_I) begin
      chan_r       <= `CH_POWER_OFF;
      cont_r       <= 1'b0;
      irq_en_r     <= 1'b0;
      done_r       <= 1'b0;
      irq_r        <= 1'b0;
      clk_cfg_r    <= `CC_RESET_VAL;
      state_r      <= ST_IDLE;
      step_r       <= 5'h00;
      sar_r        <= 10'h000;
      div_cnt_r    <= 4'h0;
      xtal_d_r     <= 1'b0;
      res_hi_r     <= 8'h00;
      res_lo_r     <= 8'h00;
      lock_r       <= 1'b0;
      first_done_r <= 1'b0;
      ACK_O        <= 1'b0;
    end else begin
      ACK_O    <= ack_nxt;
      xtal_d_r <= XTAL_TICK_I;
      if (src_tick)
        div_cnt_r <= adc_tick ? 4'h0 : div_cnt_r + 4'h1;
      if (wr & (ADR_I == `OFS_CLOCK_CONFIG))
        clk_cfg_r <= DAT_I[7:0];
      // Interlock: high read latches, low read releases
      if (rd_lo)
        lock_r <= 1'b0;
      else if (rd_hi & interlock)
        lock_r <= 1'b1;
      case (state_r)
        ST_IDLE: begin
        end
        ST_SYNC: begin
          // Wait for first converter clock; partial cycle counts as one
          if (adc_tick) begin
            state_r <= ST_CONV;
            step_r  <= 5'h00;
            sar_r   <= 10'h000;
          end
        end
        ST_CONV: begin
          if (adc_tick) begin
            if (step_r < 5'h0A)
              sar_r <= CMP_HIGH_I ? trial : sar_r;
            step_r <= step_r + 5'h01;
            if (conv_end) begin
              step_r  <= 5'h00;
              state_r <= (cont_r & powered) ? ST_CONV : ST_IDLE;
              if (cont_r)
                sar_r <= 10'h000;
            end
          end
        end
        default: state_r <= ST_IDLE;
      endcase
      if (store) begin
        case (fmt)
          FMT_RIGHT: begin
            res_hi_r <= {6'h00, final_code[9:8]};
            res_lo_r <= final_code[7:0];
          end
          FMT_SIGNED: begin
            res_hi_r <= {~final_code[9], final_code[8:2]};
            res_lo_r <= {final_code[1:0], 6'h00};
          end
          FMT_TRUNC: begin
            res_lo_r <= final_code[9:2];
          end
          default: begin
            res_hi_r <= final_code[9:2];
            res_lo_r <= {final_code[1:0], 6'h00};
          end
        endcase
      end
      // Completion events win over clears
      if (conv_end) begin
        first_done_r <= 1'b1;
        if (irq_en_r)
          irq_r <= 1'b1;
        else if (~cont_r | ~first_done_r)
          done_r <= 1'b1;
      end else if (wr_sc | rd_hi | rd_lo) begin
        done_r <= 1'b0;
        irq_r  <= 1'b0;
      end
      if (wr_sc) begin
        chan_r       <= DAT_I[4:0];
        cont_r       <= DAT_I[`SC_CONT_BIT];
        irq_en_r     <= DAT_I[`SC_IRQ_EN_BIT];
        first_done_r <= 1'b0;
        state_r      <= (DAT_I[4:0] != `CH_POWER_OFF) ? ST_SYNC : ST_IDLE;
        step_r       <= 5'h00;
        if (~conv_end) begin
          done_r <= 1'b0;
          irq_r  <= 1'b0;
        end
      end
    end
  end

  // Bus answer one cycle after request; unmapped reads give zero
  always @* begin
    ack_nxt = CYC_I & STB_I & ~ACK_O;
  end

  always @(posedge CLK_I) begin
    if (SRST_I) begin
      DAT_O <= 32'h00000000;
    end else if (rd) begin
      case (ADR_I)
        `OFS_STATUS_CONTROL:
          DAT_O <= {24'h000000, done_r & ~irq_en_r, irq_en_r, cont_r, chan_r};
        `OFS_RESULT_HIGH:    DAT_O <= {24'h000000, res_hi_r};
        `OFS_RESULT_LOW:     DAT_O <= {24'h000000, res_lo_r};
        `OFS_CLOCK_CONFIG:   DAT_O <= {24'h000000, clk_cfg_r[7:2], 2'h0};
        default:             DAT_O <= 32'h00000000;
      endcase
    end
  end
endmodule

// [bench/cmp_model.sv]
// Comparator standing in for the analog side of the converter
`timescale 1ns/1ps
module cmp_model (
  input  wire [9:0] trial_i, // Trial code from the sequencer
  input  wire [9:0] level_i, // Analog input level as a code
  output wire       high_o   // Input at or above the trial
);
  assign high_o = level_i >= trial_i;
endmodule

// [bench/sar_adc_sequencer_checker.sv]
// Port-level assertions for the converter sequencer
`timescale 1ns/1ps
module sar_adc_sequencer_checker #(parameter NCH = 10) (
  input wire           CLK_I,        // Bus clock
  input wire           SRST_I,       // Sync reset
  input wire           CYC_I,        // Bus cycle
  input wire           STB_I,        // Bus strobe
  input wire           WE_I,         // Bus write
  input wire [3:0]     ADR_I,        // Bus address
  input wire           ACK_O,        // Bus acknowledge
  input wire           IRQ_O,        // Interrupt
  input wire [4:0]     ANALOG_SEL_O, // Channel
  input wire           ANALOG_PWR_O, // Analog power
  input wire [NCH-1:0] PORT_OUT_I,   // Port levels
  input wire [NCH-1:0] PORT_DIR_I,   // Port directions
  input wire [NCH-1:0] PIN_OUT_O,    // Pin levels
  input wire [NCH-1:0] PIN_OE_O,     // Pin enables
  input wire [NCH-1:0] PORT_READ_O   // Port read levels
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SRST_I);
  wire claim = ANALOG_SEL_O < NCH;
  ack_rise_a: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O) else $error("no ack");
  ack_drop_a: assert property (ACK_O |=> !ACK_O) else $error("ack held");
  pin_claim_a: assert property (claim |-> !PIN_OE_O[ANALOG_SEL_O]) else $error("pin driven");
  port_read_a: assert property (claim |-> !PORT_READ_O[ANALOG_SEL_O]) else $error("read 1");
  pin_free_a: assert property (ANALOG_SEL_O == 5'h1F |-> PIN_OE_O == PORT_DIR_I
    && PIN_OUT_O == PORT_OUT_I) else $error("pins not passed");
  power_off_a: assert property (ANALOG_PWR_O == (ANALOG_SEL_O != 5'h1F)) else $error("pwr");
  sel_write_a: assert property ($changed(ANALOG_SEL_O) && !$past(SRST_I) |-> ACK_O && WE_I)
    else $error("channel moved");
  irq_abort_a: assert property (ACK_O && WE_I && ADR_I == 4'h0 |=> !$rose(IRQ_O))
    else $error("irq after write");
  cover property ($rose(IRQ_O));
  cover property (claim);
  cover property (ACK_O && !WE_I && ADR_I == 4'h8);
endmodule
bind sar_adc_sequencer sar_adc_sequencer_checker #(.NCH(NCH)) i_chk (.CLK_I(CLK_I),
  .SRST_I(SRST_I), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I), .ACK_O(ACK_O),
  .IRQ_O(IRQ_O), .ANALOG_SEL_O(ANALOG_SEL_O), .ANALOG_PWR_O(ANALOG_PWR_O),
  .PORT_OUT_I(PORT_OUT_I), .PORT_DIR_I(PORT_DIR_I), .PIN_OUT_O(PIN_OUT_O),
  .PIN_OE_O(PIN_OE_O), .PORT_READ_O(PORT_READ_O));

// [bench/sar_adc_sequencer_tb.sv]
// Register-level bench for the converter sequencer
`timescale 1ns/1ps
module sar_adc_sequencer_tb;
  reg         CLK_I = 1'h0, SRST_I = 1'h1, CYC_I = 1'h0, STB_I = 1'h0, WE_I = 1'h0;
  reg         XTAL_TICK_I = 1'h0;
  reg  [3:0]  ADR_I = 4'h0, SEL_I = 4'hF;
  reg  [31:0] DAT_I = 32'h0;
  reg  [9:0]  PORT_OUT_I = 10'h3FF, PORT_DIR_I = 10'h3FF, PIN_LEVEL_I = 10'h3FF;
  reg  [9:0]  vin = 10'h155;
  wire [31:0] DAT_O;
  wire        ACK_O, CMP_HIGH_I, ANALOG_PWR_O, IRQ_O;
  wire [9:0]  TRIAL_CODE_O, PIN_OUT_O, PIN_OE_O, PORT_READ_O;
  wire [4:0]  ANALOG_SEL_O;
  integer     failures = 0, checks = 0, i, n, dv;
  reg  [7:0]  q;
  localparam [47:0] HI_T = 48'h807F000300FF;
  localparam [31:0] CFG_T = 32'h24F49414;
  always #2.5 CLK_I = ~CLK_I;
  always @(posedge CLK_I) XTAL_TICK_I <= ~XTAL_TICK_I;
  sar_adc_sequencer i_dut (.CLK_I(CLK_I), .SRST_I(SRST_I), .CYC_I(CYC_I), .STB_I(STB_I),
    .WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O),
    .XTAL_TICK_I(XTAL_TICK_I), .CMP_HIGH_I(CMP_HIGH_I), .TRIAL_CODE_O(TRIAL_CODE_O),
    .ANALOG_SEL_O(ANALOG_SEL_O), .ANALOG_PWR_O(ANALOG_PWR_O), .IRQ_O(IRQ_O),
    .PORT_OUT_I(PORT_OUT_I), .PORT_DIR_I(PORT_DIR_I), .PIN_LEVEL_I(PIN_LEVEL_I),
    .PIN_OUT_O(PIN_OUT_O), .PIN_OE_O(PIN_OE_O), .PORT_READ_O(PORT_READ_O));
  cmp_model i_cmp (.trial_i(TRIAL_CODE_O), .level_i(vin), .high_o(CMP_HIGH_I));
  task wrap_up;
    begin
      if (failures == 0 && checks > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  task chk(input [31:0] s, input [31:0] e);
    begin
      checks = checks + 1;
      if (s !== e) begin
        failures = failures + 1;
        $display("BAD %0t seen %h expected %h", $time, s, e);
      end
    end
  endtask
  // One classic cycle; returns after strobe has been low for a cycle
  task bus(input [3:0] a, input w, input [7:0] d);
    integer k;
    begin
      CYC_I <= 1'h1; STB_I <= 1'h1; WE_I <= w; ADR_I <= a; DAT_I <= {24'h0, d};
      k = 0;
      @(posedge CLK_I);
      while (ACK_O !== 1'h1 && k < 20) begin
        @(posedge CLK_I);
        k = k + 1;
      end
      if (ACK_O !== 1'h1) begin
        failures = failures + 1;
        wrap_up;
      end
      q = DAT_O[7:0];
      CYC_I <= 1'h0; STB_I <= 1'h0; WE_I <= 1'h0;
      @(posedge CLK_I);
    end
  endtask
  task rd(input [3:0] a, input [7:0] e);
    begin
      bus(a, 1'h0, 8'h00);
      chk(q, e);
    end
  endtask
  task wait_done;
    begin
      n = 0;
      q = 8'h00;
      while (q[7] !== 1'h1 && n < 100) begin
        bus(4'h0, 1'h0, 8'h00);
        n = n + 1;
      end
      if (q[7] !== 1'h1) begin
        failures = failures + 1;
        wrap_up;
      end
    end
  endtask
  initial begin
    repeat (6) @(posedge CLK_I);
    SRST_I <= 1'h0;
    rd(4'h0, 8'h1F);
    rd(4'hC, 8'h00);
    rd(4'h2, 8'h00);
    // Reference inputs in every format
    for (i = 0; i < 8; i = i + 1) begin
      bus(4'hC, 1'h1, {3'h0, 1'h1, i[2:1], 2'h0});
      bus(4'h0, 1'h1, i[0] ? 8'h1E : 8'h1D);
      wait_done;
      bus(4'h4, 1'h0, 8'h00);
      if (i < 6) chk(q, HI_T[i*8+:8]);
      bus(4'h8, 1'h0, 8'h00);
      chk(q, i[0] ? 8'h00 : (i[1] ? 8'hFF : 8'hC0));
      rd(4'h0, i[0] ? 8'h1E : 8'h1D);
    end
    // Conversion length per source and prescale
    for (i = 0; i < 4; i = i + 1) begin
      dv = (i == 0) ? 1 : (i == 3) ? 4 : 16;
      bus(4'hC, 1'h1, CFG_T[i*8+:8]);
      bus(4'h0, 1'h1, 8'h5E);
      n = 0;
      while (IRQ_O !== 1'h1 && n < 400) begin
        @(posedge CLK_I);
        n = n + 1;
      end
      if (IRQ_O !== 1'h1) begin
        failures = failures + 1;
        wrap_up;
      end
      chk(n >= 16 * dv - 2 && n <= 17 * dv + 6, 1);
      rd(4'h0, 8'h5E);
      rd(4'h4, 8'h00);
      rd(4'h8, 8'h00);
      chk(IRQ_O, 1'h0);
    end
    bus(4'hC, 1'h1, 8'h14);
    bus(4'h0, 1'h1, 8'h23);
    chk(PIN_OE_O, 10'h3F7);
    chk(PIN_OUT_O, 10'h3F7);
    chk(PORT_READ_O, 10'h3F7);
    wait_done;
    rd(4'h4, 8'h01);
    rd(4'h8, 8'h55);
    vin <= 10'h2AA;
    repeat (60) @(posedge CLK_I);
    rd(4'h4, 8'h02);
    vin <= 10'h0CC;
    repeat (60) @(posedge CLK_I);
    rd(4'h8, 8'hAA);
    repeat (60) @(posedge CLK_I);
    rd(4'h4, 8'h00);
    rd(4'h8, 8'hCC);
    rd(4'h0, 8'h23);
    bus(4'h0, 1'h1, 8'h1F);
    chk(ANALOG_PWR_O, 1'h0);
    chk(PORT_READ_O, 10'h3FF);
    wrap_up;
  end
endmodule
